//--- rtl/ivsm_defines.svh
`ifndef IVSM_DEFINES_SVH
`define IVSM_DEFINES_SVH

// polling slots, slot 0 highest
`define IVSM_NUM_SLOTS      11
`define IVSM_SLOT_PIN0      1
`define IVSM_SLOT_TMR0      2
`define IVSM_SLOT_PIN1      3
`define IVSM_SLOT_TMR1      4
`define IVSM_SLOT_TMR2      6
`define IVSM_SLOT_UART1     7
`define IVSM_SLOT_EXT8      8
`define IVSM_SLOT_EXT9      9
`define IVSM_SLOT_EXT10     10

// vector address per slot
`define IVSM_VEC_S0         8'h33
`define IVSM_VEC_S1         8'h03
`define IVSM_VEC_S2         8'h0b
`define IVSM_VEC_S3         8'h13
`define IVSM_VEC_S4         8'h1b
`define IVSM_VEC_S5         8'h23
`define IVSM_VEC_S6         8'h2b
`define IVSM_VEC_S7         8'h3b
`define IVSM_VEC_S8         8'h43
`define IVSM_VEC_S9         8'h4b
`define IVSM_VEC_S10        8'h53

// interrupt number per slot
`define IVSM_NUM_S0         4'h6
`define IVSM_NUM_S1         4'h0
`define IVSM_NUM_S2         4'h1
`define IVSM_NUM_S3         4'h2
`define IVSM_NUM_S4         4'h3
`define IVSM_NUM_S5         4'h4
`define IVSM_NUM_S6         4'h5
`define IVSM_NUM_S7         4'h7
`define IVSM_NUM_S8         4'h8
`define IVSM_NUM_S9         4'h9
`define IVSM_NUM_S10        4'ha

// main enable register bit positions (priority bits share them)
`define IVSM_MEN_PIN0       0
`define IVSM_MEN_TMR0       1
`define IVSM_MEN_PIN1       2
`define IVSM_MEN_TMR1       3
`define IVSM_MEN_TMR2       5
`define IVSM_MEN_UART1      6
`define IVSM_MEN_GLOBAL     7

// extended enable register bit positions
`define IVSM_XEN_EXT8       0
`define IVSM_XEN_EXT9       1
`define IVSM_XEN_EXT10      2

// source group bit positions and usable-bit masks
`define IVSM_GRPC_RTC_BAD   0
`define IVSM_GRPC_PIN2      2
`define IVSM_GRPC_PIN3      3
`define IVSM_GRPA_MASK      8'hbf
`define IVSM_GRPB_MASK      8'hec
`define IVSM_GRPC_MASK      8'h0d

`endif

//--- rtl/ivsm_pkg.sv
package ivsm_pkg;

  // peripheral event pulses, one sys_clk cycle each
  typedef struct packed {
    logic       tmr0_ovf;
    logic       tmr1_ovf;
    logic       tmr2_ovf;
    logic       tmr2_ext;
    logic       uart1_rx;
    logic       uart1_tx;
    logic [7:0] grp_a;
    logic [7:0] grp_b;
    logic       rtc_bad_data;
  } ivsm_evt_s;

  // software clear strobes, one cycle each
  typedef struct packed {
    logic       pin0;
    logic       tmr0;
    logic       pin1;
    logic       tmr1;
    logic       tmr2_ovf;
    logic       tmr2_ext;
    logic       uart1_rx;
    logic       uart1_tx;
    logic [2:0] ext;
    logic [7:0] grp_a;
    logic [7:0] grp_b;
    logic [7:0] grp_c;
  } ivsm_clr_s;

  // flag state presented to the core
  typedef struct packed {
    logic       pin0;
    logic       tmr0;
    logic       pin1;
    logic       tmr1;
    logic       tmr2_ovf;
    logic       tmr2_ext;
    logic       uart1_rx;
    logic       uart1_tx;
    logic [2:0] ext;
    logic [7:0] grp_a;
    logic [7:0] grp_b;
    logic [7:0] grp_c;
  } ivsm_flag_s;

  // service nesting state
  typedef enum logic [1:0] {
    SVC_IDLE,
    SVC_LO,
    SVC_HI,
    SVC_HI_ON_LO
  } ivsm_svc_e;

endpackage : ivsm_pkg

//--- rtl/ivsm_pin_edge.sv
`timescale 1ns/100ps
`default_nettype none

module ivsm_pin_edge (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] pin_n,
  output logic      [3:0] pin_low_r,
  output logic      [3:0] pin_fall_r
);

  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] prev_r;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
      // two flops before any logic; idle level of a pin is high
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          meta_r[g]     <= 1'b1;
          sync_r[g]     <= 1'b1;
          prev_r[g]     <= 1'b1;
          pin_low_r[g]  <= 1'b0;
          pin_fall_r[g] <= 1'b0;
        end else begin
          meta_r[g]     <= pin_n[g];
          sync_r[g]     <= meta_r[g];
          prev_r[g]     <= sync_r[g];
          pin_low_r[g]  <= ~sync_r[g];
          pin_fall_r[g] <= prev_r[g] & ~sync_r[g];
        end
      end
    end
  endgenerate

endmodule : ivsm_pin_edge

`default_nettype wire

//--- rtl/ivsm_core.sv
`include "ivsm_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module ivsm_core
  import ivsm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       pin_irq_zero_n,
  input  wire logic       pin_irq_one_n,
  input  wire logic       pin_irq_two_n,
  input  wire logic       pin_irq_three_n,
  input  wire logic       pin0_edge_mode,
  input  wire logic       pin1_edge_mode,
  input  wire logic [7:0] main_irq_enable_reg,
  input  wire logic [7:0] extended_irq_enable_reg,
  input  wire logic [7:0] src_group_a_enable,
  input  wire logic [7:0] src_group_b_enable,
  input  wire logic [7:0] src_group_c_enable,
  input  wire logic [7:0] prio_main,
  input  wire logic [7:0] prio_ext,
  input  wire ivsm_evt_s  periph_evt,
  input  wire ivsm_clr_s  flag_clr,
  input  wire logic       irq_ack,
  input  wire logic       irq_return,
  output ivsm_flag_s      flags_r,
  output logic            irq_req_r,
  output logic      [7:0] irq_vector_r,
  output logic      [3:0] irq_number_r,
  output logic            irq_level_r,
  output ivsm_svc_e       svc_state_r
);

  // lowest index wins, which is the polling order
  // polling order scan
  function automatic logic [3:0] first_set(input logic [10:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 10; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_set

  // vector address of a polling slot
  // reserved slots keep an entry so the table stays complete
  function automatic logic [7:0] slot_vector(input logic [3:0] s);
    logic [7:0] v;
    v = `IVSM_VEC_S0;
    unique case (s)
      4'h0: v = `IVSM_VEC_S0;
      4'h1: v = `IVSM_VEC_S1;
      4'h2: v = `IVSM_VEC_S2;
      4'h3: v = `IVSM_VEC_S3;
      4'h4: v = `IVSM_VEC_S4;
      4'h5: v = `IVSM_VEC_S5;
      4'h6: v = `IVSM_VEC_S6;
      4'h7: v = `IVSM_VEC_S7;
      4'h8: v = `IVSM_VEC_S8;
      4'h9: v = `IVSM_VEC_S9;
      4'ha: v = `IVSM_VEC_S10;
      default: v = `IVSM_VEC_S0;
    endcase
    return v;
  endfunction : slot_vector

  // interrupt number of a polling slot
  // numbers follow the same slot order as the vectors
  function automatic logic [3:0] slot_number(input logic [3:0] s);
    logic [3:0] n;
    n = `IVSM_NUM_S0;
    unique case (s)
      4'h0: n = `IVSM_NUM_S0;
      4'h1: n = `IVSM_NUM_S1;
      4'h2: n = `IVSM_NUM_S2;
      4'h3: n = `IVSM_NUM_S3;
      4'h4: n = `IVSM_NUM_S4;
      4'h5: n = `IVSM_NUM_S5;
      4'h6: n = `IVSM_NUM_S6;
      4'h7: n = `IVSM_NUM_S7;
      4'h8: n = `IVSM_NUM_S8;
      4'h9: n = `IVSM_NUM_S9;
      4'ha: n = `IVSM_NUM_S10;
      default: n = `IVSM_NUM_S0;
    endcase
    return n;
  endfunction : slot_number

  // synchronised pins
  // pins are asynchronous; both sync flops sit in the edge module
  logic [3:0]  pin_low;
  logic [3:0]  pin_fall;

  ivsm_pin_edge u_pin_edge (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .pin_n      ({pin_irq_three_n, pin_irq_two_n,
                  pin_irq_one_n, pin_irq_zero_n}),
    .pin_low_r  (pin_low),
    .pin_fall_r (pin_fall)
  );

  // internal state
  logic [3:0]  irq_slot_r;
  ivsm_flag_s  flags_nxt;
  ivsm_svc_e   svc_state_nxt;

  // acknowledge decode, one-hot on the granted slot
  // an ack while no request stands is dropped here
  wire         ack_take = irq_ack & irq_req_r;
  wire  [10:0] ack_oh   = ack_take ? (11'h001 << irq_slot_r) : 11'h000;

  // source group event vectors with reserved bits removed
  wire  [7:0]  grp_c_evt;
  wire  [7:0]  evt_a    = periph_evt.grp_a & `IVSM_GRPA_MASK;
  wire  [7:0]  evt_b    = periph_evt.grp_b & `IVSM_GRPB_MASK;
  wire  [7:0]  evt_c    = grp_c_evt & `IVSM_GRPC_MASK;

  assign grp_c_evt = {4'h0, pin_fall[3], pin_fall[2], 1'b0,
                      periph_evt.rtc_bad_data};

  // enabled pending sources per group
  // masking here too keeps a stray enable off reserved bits
  wire  [7:0]  live_a = flags_r.grp_a & src_group_a_enable & `IVSM_GRPA_MASK;
  wire  [7:0]  live_b = flags_r.grp_b & src_group_b_enable & `IVSM_GRPB_MASK;
  wire  [7:0]  live_c = flags_r.grp_c & src_group_c_enable & `IVSM_GRPC_MASK;

  // an enabled source event raises the extended flag
  wire  [2:0]  ext_set = {|(evt_c & src_group_c_enable),
                          |(evt_b & src_group_b_enable),
                          |(evt_a & src_group_a_enable)};

  // hardware clears for edge-mode pins 0 and 1 and timers 0 and 1 happen on the grant
  wire         clr_pin0 = flag_clr.pin0 | ack_oh[`IVSM_SLOT_PIN0];
  wire         clr_pin1 = flag_clr.pin1 | ack_oh[`IVSM_SLOT_PIN1];
  wire         clr_tmr0 = flag_clr.tmr0 | ack_oh[`IVSM_SLOT_TMR0];
  wire         clr_tmr1 = flag_clr.tmr1 | ack_oh[`IVSM_SLOT_TMR1];

  // flag next state; everywhere a set beats a clear in the same cycle
  always_comb begin
    flags_nxt = flags_r;
    // level mode is not latched; the flag drops with the pin
    // pin zero mode
    flags_nxt.pin0 = pin0_edge_mode ?
                     (pin_fall[0] | (flags_r.pin0 & ~clr_pin0)) :
                     pin_low[0];
    flags_nxt.pin1 = pin1_edge_mode ?
                     (pin_fall[1] | (flags_r.pin1 & ~clr_pin1)) :
                     pin_low[1];
    flags_nxt.tmr0 = periph_evt.tmr0_ovf | (flags_r.tmr0 & ~clr_tmr0);
    flags_nxt.tmr1 = periph_evt.tmr1_ovf | (flags_r.tmr1 & ~clr_tmr1);
    flags_nxt.tmr2_ovf = periph_evt.tmr2_ovf |
                         (flags_r.tmr2_ovf & ~flag_clr.tmr2_ovf);
    flags_nxt.tmr2_ext = periph_evt.tmr2_ext |
                         (flags_r.tmr2_ext & ~flag_clr.tmr2_ext);
    flags_nxt.uart1_rx = periph_evt.uart1_rx |
                         (flags_r.uart1_rx & ~flag_clr.uart1_rx);
    flags_nxt.uart1_tx = periph_evt.uart1_tx |
                         (flags_r.uart1_tx & ~flag_clr.uart1_tx);
    flags_nxt.grp_a = evt_a | (flags_r.grp_a & ~flag_clr.grp_a);
    flags_nxt.grp_b = evt_b | (flags_r.grp_b & ~flag_clr.grp_b);
    flags_nxt.grp_c = evt_c | (flags_r.grp_c & ~flag_clr.grp_c);
    flags_nxt.ext = ext_set | (flags_r.ext & ~flag_clr.ext);
  end

  // raw requests per polling slot, before the global gate
  wire  [10:0] slot_req;
  // the global enable gates every slot, extended ones too
  wire         glob_en = main_irq_enable_reg[`IVSM_MEN_GLOBAL];

  assign slot_req[0] = 1'b0;
  assign slot_req[5] = 1'b0;
  assign slot_req[`IVSM_SLOT_PIN0] =
      main_irq_enable_reg[`IVSM_MEN_PIN0] & flags_r.pin0;
  assign slot_req[`IVSM_SLOT_TMR0] =
      main_irq_enable_reg[`IVSM_MEN_TMR0] & flags_r.tmr0;
  assign slot_req[`IVSM_SLOT_TMR1] =
      main_irq_enable_reg[`IVSM_MEN_TMR1] & flags_r.tmr1;
  assign slot_req[`IVSM_SLOT_PIN1] =
      main_irq_enable_reg[`IVSM_MEN_PIN1] & flags_r.pin1;
  assign slot_req[`IVSM_SLOT_TMR2] =
      main_irq_enable_reg[`IVSM_MEN_TMR2] &
      (flags_r.tmr2_ovf | flags_r.tmr2_ext);
  assign slot_req[`IVSM_SLOT_UART1] =
      main_irq_enable_reg[`IVSM_MEN_UART1] &
      (flags_r.uart1_rx | flags_r.uart1_tx);
  assign slot_req[`IVSM_SLOT_EXT8] =
      extended_irq_enable_reg[`IVSM_XEN_EXT8] & flags_r.ext[0] & |live_a;
  assign slot_req[`IVSM_SLOT_EXT9] =
      extended_irq_enable_reg[`IVSM_XEN_EXT9] & flags_r.ext[1] & |live_b;
  assign slot_req[`IVSM_SLOT_EXT10] =
      extended_irq_enable_reg[`IVSM_XEN_EXT10] & flags_r.ext[2] & |live_c;

  // priority level per slot; reserved slots sit low
  // per slot level
  wire  [10:0] slot_hi = {prio_ext[`IVSM_XEN_EXT10],
                          prio_ext[`IVSM_XEN_EXT9],
                          prio_ext[`IVSM_XEN_EXT8],
                          prio_main[`IVSM_MEN_UART1],
                          prio_main[`IVSM_MEN_TMR2],
                          1'b0,
                          prio_main[`IVSM_MEN_TMR1],
                          prio_main[`IVSM_MEN_PIN1],
                          prio_main[`IVSM_MEN_TMR0],
                          prio_main[`IVSM_MEN_PIN0],
                          1'b0};

  wire  [10:0] req_all = glob_en ? slot_req : 11'h000;
  wire  [10:0] req_hi  = req_all & slot_hi;
  wire  [10:0] req_lo  = req_all & ~slot_hi;
  wire         any_hi  = |req_hi;
  wire         any_lo  = |req_lo;
  wire  [3:0]  win     = any_hi ? first_set(req_hi) : first_set(req_lo);

  // HI and HI_ON_LO block all; there is no third level
  // only a strictly higher level may interrupt
  wire         allowed = (svc_state_r == SVC_IDLE) ? (any_hi | any_lo) :
                         (svc_state_r == SVC_LO)   ? any_hi : 1'b0;

  // the grant edge itself drops the request so it is not seen twice
  // without this the core could take one slot on two edges
  wire         req_nxt = allowed & ~ack_take;

  // nesting bookkeeping on grant and return
  always_comb begin
    svc_state_nxt = svc_state_r;
    unique case (svc_state_r)
      SVC_IDLE: begin
        if (ack_take) begin
          svc_state_nxt = irq_level_r ? SVC_HI : SVC_LO;
        end
      end
      SVC_LO: begin
        if (ack_take && irq_level_r) begin
          svc_state_nxt = SVC_HI_ON_LO;
        end else if (irq_return) begin
          svc_state_nxt = SVC_IDLE;
        end
      end
      SVC_HI: begin
        if (irq_return) begin
          svc_state_nxt = SVC_IDLE;
        end
      end
      SVC_HI_ON_LO: begin
        if (irq_return) begin
          svc_state_nxt = SVC_LO;
        end
      end
    endcase
  end

  // flag and nesting registers
  // a set beats a clear, so a pulse during a clear is kept
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags_r     <= '0;
      svc_state_r <= SVC_IDLE;
    end else begin
      flags_r     <= flags_nxt;
      svc_state_r <= svc_state_nxt;
    end
  end

  // request towards the core; held fields follow the winner each cycle
  // a late ack therefore takes whatever wins at that edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_req_r    <= 1'b0;
      irq_slot_r   <= 4'h0;
      irq_vector_r <= 8'h00;
      irq_number_r <= 4'h0;
      irq_level_r  <= 1'b0;
    end else if (!ack_take) begin
      irq_req_r    <= req_nxt;
      irq_slot_r   <= win;
      irq_vector_r <= slot_vector(win);
      irq_number_r <= slot_number(win);
      irq_level_r  <= any_hi;
    end else begin
      irq_req_r    <= 1'b0;
    end
  end

endmodule : ivsm_core

`default_nettype wire

//--- dv/ivsm_core_properties.sv
`timescale 1ns/100ps
`default_nettype none

module ivsm_core_properties
  import ivsm_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic [7:0] main_irq_enable_reg,
  input wire logic [7:0] src_group_a_enable,
  input wire ivsm_evt_s  periph_evt,
  input wire logic       irq_ack,
  input wire logic       irq_return,
  input wire ivsm_flag_s flags_r,
  input wire logic       irq_req_r,
  input wire logic [7:0] irq_vector_r,
  input wire logic [3:0] irq_number_r,
  input wire logic       irq_level_r,
  input wire ivsm_svc_e  svc_state_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // a grant is an ack while a request stands
  sequence s_taken;
    irq_ack && irq_req_r;
  endsequence
  // three cycles give the request register time to settle
  sequence s_hi3;
    (svc_state_r == SVC_HI) [*3];
  endsequence
  sequence s_lo3;
    (svc_state_r == SVC_LO) [*3];
  endsequence

  chk_resv_clear:
    assert property (((flags_r.grp_a & 8'h40) | (flags_r.grp_b & 8'h13)
      | (flags_r.grp_c & 8'hf2)) == 8'h00)
    else $error("reserved group flag set");
  chk_grpa_set:
    assert property (periph_evt.grp_a != 8'h00 |=>
      (flags_r.grp_a & $past(periph_evt.grp_a) & 8'hbf)
      == ($past(periph_evt.grp_a) & 8'hbf))
    else $error("group a flag missed");
  chk_grpb_set:
    assert property (periph_evt.grp_b != 8'h00 |=>
      (flags_r.grp_b & $past(periph_evt.grp_b) & 8'hec)
      == ($past(periph_evt.grp_b) & 8'hec))
    else $error("group b flag missed");
  chk_ext8_set:
    assert property ((periph_evt.grp_a & src_group_a_enable & 8'hbf)
      != 8'h00 |=> flags_r.ext[0])
    else $error("extended 8 flag missed");
  chk_uart1_set:
    assert property ((periph_evt.uart1_rx |=> flags_r.uart1_rx)
      and (periph_evt.uart1_tx |=> flags_r.uart1_tx))
    else $error("uart1 flag missed");
  chk_vec_map:
    assert property (irq_req_r |-> irq_vector_r == {1'b0, irq_number_r,
      3'b011} && !(irq_number_r inside {4'h4, 4'h6}))
    else $error("vector does not match number");
  chk_global_off:
    assert property ((!main_irq_enable_reg[7]) [*3] |-> !irq_req_r)
    else $error("request with global enable off");
  chk_ack_drop:
    assert property (s_taken |=> !irq_req_r)
    else $error("request stands after grant");
  chk_ack_level:
    assert property (s_taken ##0 svc_state_r == SVC_IDLE |=>
      svc_state_r == ($past(irq_level_r) ? SVC_HI : SVC_LO))
    else $error("wrong service level after grant");
  chk_hi_blocks:
    assert property (s_hi3 |-> !irq_req_r)
    else $error("request during high service");
  chk_lo_preempt:
    assert property (s_lo3 ##0 irq_req_r |-> irq_level_r)
    else $error("low request during low service");
  chk_ret_pop:
    assert property (irq_return && !irq_ack && svc_state_r == SVC_HI
      |=> svc_state_r == SVC_IDLE)
    else $error("return did not end service");
endmodule : ivsm_core_properties

bind ivsm_core ivsm_core_properties u_props (
  .sys_clk(sys_clk), .rstn(rstn),
  .main_irq_enable_reg(main_irq_enable_reg),
  .src_group_a_enable(src_group_a_enable), .periph_evt(periph_evt),
  .irq_ack(irq_ack), .irq_return(irq_return), .flags_r(flags_r),
  .irq_req_r(irq_req_r), .irq_vector_r(irq_vector_r),
  .irq_number_r(irq_number_r), .irq_level_r(irq_level_r),
  .svc_state_r(svc_state_r)
);

`default_nettype wire

//--- dv/ivsm_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

module ivsm_cpu_model
  import ivsm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       irq_req_r,
  input  wire logic [3:0] irq_number_r,
  input  wire ivsm_flag_s flags_r,
  input  wire logic [2:0] ack_delay,
  output logic            irq_ack,
  output logic            irq_return,
  output ivsm_clr_s       flag_clr
);
  // one routine; a higher level request may nest inside its body
  task automatic serve();
    logic [3:0] n;
    ivsm_clr_s  c;
    n = irq_number_r;
    irq_ack = 1'b1;
    @(negedge sys_clk);
    irq_ack = 1'b0;
    // routine body; only a higher level can be presented here
    repeat (4) begin
      @(negedge sys_clk);
      if (irq_req_r === 1'b1) serve();
    end
    c = '0;
    case (n)
      4'h5: c.tmr2_ovf = 1'b1;
      4'h7: c.uart1_rx = 1'b1;
      4'h8: c.grp_a = flags_r.grp_a;
      4'h9: c.grp_b = flags_r.grp_b;
      4'ha: c.grp_c = flags_r.grp_c;
      default: ;
    endcase
    c.tmr2_ext = (n == 4'h5);
    c.uart1_tx = (n == 4'h7);
    flag_clr = c;
    @(negedge sys_clk);
    c = '0;
    if (n >= 4'h8) c.ext = 3'(3'b001 << (n - 4'h8));
    flag_clr = c;
    @(negedge sys_clk);
    flag_clr = '0;
    irq_return = 1'b1;
    @(negedge sys_clk);
    irq_return = 1'b0;
  endtask : serve

  // takes a standing request after the programmed delay
  initial begin
    irq_ack = 1'b0;
    irq_return = 1'b0;
    flag_clr = '0;
    forever begin
      @(negedge sys_clk);
      if (irq_req_r === 1'b1) begin
        repeat (ack_delay) @(negedge sys_clk);
        if (irq_req_r === 1'b1) serve();
      end
    end
  end
endmodule : ivsm_cpu_model

`default_nettype wire

//--- dv/tb_ivsm_core.sv
`timescale 1ns/100ps
`default_nettype none

module tb_ivsm_core
  import ivsm_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rstn;
  logic [3:0] pin_n;
  logic [1:0] edge_mode;
  logic [7:0] men, xen, en_a, en_b, en_c, p_main, p_ext, vec;
  ivsm_evt_s  evt;
  ivsm_flag_s flags;
  ivsm_clr_s  clr;
  ivsm_svc_e  svc;
  logic       ack, ret, req, lvl;
  logic [3:0] num;
  logic [2:0] dly;
  int         num_errors = 0;
  int         n_tests = 0;
  int         seed = 2;

  always #2.5 sys_clk = ~sys_clk;

  ivsm_core DUT (
    .sys_clk(sys_clk), .rstn(rstn), .pin_irq_zero_n(pin_n[0]),
    .pin_irq_one_n(pin_n[1]), .pin_irq_two_n(pin_n[2]),
    .pin_irq_three_n(pin_n[3]), .pin0_edge_mode(edge_mode[0]),
    .pin1_edge_mode(edge_mode[1]), .main_irq_enable_reg(men),
    .extended_irq_enable_reg(xen), .src_group_a_enable(en_a),
    .src_group_b_enable(en_b), .src_group_c_enable(en_c),
    .prio_main(p_main), .prio_ext(p_ext), .periph_evt(evt),
    .flag_clr(clr), .irq_ack(ack), .irq_return(ret), .flags_r(flags),
    .irq_req_r(req), .irq_vector_r(vec), .irq_number_r(num),
    .irq_level_r(lvl), .svc_state_r(svc)
  );

  ivsm_cpu_model u_cpu (
    .sys_clk(sys_clk), .irq_req_r(req), .irq_number_r(num),
    .flags_r(flags), .ack_delay(dly), .irq_ack(ack),
    .irq_return(ret), .flag_clr(clr)
  );

  function automatic logic [7:0] vec_of(input logic [3:0] n);
    return {1'b0, n, 3'b011};
  endfunction : vec_of

  task automatic check(input string what, input logic [7:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check

  // bounded wait so a lost request fails instead of hanging
  task automatic check_irq(input logic [3:0] n);
    for (int i = 0; i < 14 && req !== 1'b1; i++) @(negedge sys_clk);
    check("irq_req", 8'h01, {7'h0, req});
    check("irq_number", {4'h0, n}, {4'h0, num});
    check("irq_vector", vec_of(n), vec);
  endtask : check_irq

  task automatic fire(input ivsm_evt_s e);
    evt = e;
    @(negedge sys_clk);
    evt = '0;
  endtask : fire

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // watchdog, far beyond the fewer than a thousand cycles needed
  initial begin
    #50000;
    num_errors++;
    finish_test();
  end

  initial begin
    ivsm_evt_s  e;
    logic [7:0] r, m;
    logic [3:0] exp_n [6];
    exp_n = '{4'h1, 4'h3, 4'h5, 4'h5, 4'h7, 4'h7};
    rstn = 1'b0;
    pin_n = 4'hf;
    edge_mode = 2'b11;
    {men, xen, en_a, en_b, en_c} = {8'hff, 8'h07, 24'hffffff};
    {p_main, p_ext} = 16'h0000;
    evt = '0;
    dly = 3'd3;
    idle(3);
    check("svc_reset", 8'h00, {6'h0, svc});
    check("req_reset", 8'h00, {7'h0, req});
    rstn = 1'b1;
    // main sources one at a time
    for (int k = 0; k < 6; k++) begin
      fire(ivsm_evt_s'(23'h400000 >> k));
      check_irq(exp_n[k]);
      idle(12);
    end
    // random group events, awkward cases among them
    for (int k = 0; k < 20; k++) begin
      r = (k < 12) ? 8'($random(seed)) : (8'h01 << (k - 12));
      dly = 3'($random(seed) & 7);
      m = k[0] ? 8'hec : 8'hbf;
      if ((r & m) == 8'h00) r = 8'h80;
      e = '0;
      if (k[0]) e.grp_b = r;
      else e.grp_a = r;
      fire(e);
      @(negedge sys_clk);
      check("grp_flag", r & m, k[0] ? flags.grp_b : flags.grp_a);
      check_irq(k[0] ? 4'h9 : 4'h8);
      idle(16);
    end
    dly = 3'd3;
    e = '0;
    {e.grp_a, e.grp_b} = 16'h4013;
    fire(e);
    idle(3);
    check("resv_flag", 8'h00, flags.grp_a | flags.grp_b);
    check("resv_req", 8'h00, {7'h0, req});
    // flag without an enabled source raises nothing
    en_a = 8'h00;
    e = '0;
    e.grp_a = 8'h01;
    fire(e);
    idle(3);
    check("ext_flag", 8'h00, {5'h0, flags.ext});
    check("grp_a_flag", 8'h01, flags.grp_a);
    en_a = 8'hff;
    e.grp_a = 8'h02;
    fire(e);
    check_irq(4'h8);
    idle(12);
    men[7] = 1'b0;
    fire(ivsm_evt_s'(23'h040000));
    idle(4);
    check("req_global_off", 8'h00, {7'h0, req});
    men[7] = 1'b1;
    check_irq(4'h7);
    idle(12);
    // same level by polling order, high level first
    for (int k = 0; k < 2; k++) begin
      p_ext = 8'(k);
      e = '0;
      e.uart1_rx = 1'b1;
      e.grp_a = 8'h80;
      fire(e);
      check_irq(k ? 4'h8 : 4'h7);
      check("irq_level", 8'(k), {7'h0, lvl});
      idle(6);
      check_irq(k ? 4'h7 : 4'h8);
      check("irq_level", 8'h00, {7'h0, lvl});
      idle(12);
    end
    // a high level request preempts a low routine and nests
    p_ext = 8'h01;
    fire(ivsm_evt_s'(23'h040000));
    check_irq(4'h7);
    idle(4);
    e = '0;
    e.grp_a = 8'h80;
    fire(e);
    check_irq(4'h8);
    check("irq_level", 8'h01, {7'h0, lvl});
    idle(2);
    check("svc_nested", {6'h0, SVC_HI_ON_LO}, {6'h0, svc});
    idle(8);
    check("svc_resume", {6'h0, SVC_LO}, {6'h0, svc});
    idle(6);
    check("svc_done", {6'h0, SVC_IDLE}, {6'h0, svc});
    p_ext = 8'h00;
    fire(ivsm_evt_s'(23'h000001));
    check_irq(4'ha);
    idle(12);
    // falling edge pins of group c fire once per edge
    dly = 3'd2;
    for (int k = 2; k < 4; k++) begin
      pin_n[k] = 1'b0;
      check_irq(4'ha);
      idle(16);
      check("pin_c_once", 8'h00, {7'h0, req} | flags.grp_c);
      pin_n[k] = 1'b1;
      idle(4);
    end
    // pins zero and one in level and edge mode
    for (int k = 0; k < 4; k++) begin
      edge_mode = k[1] ? 2'b11 : 2'b00;
      pin_n[k[0]] = 1'b0;
      check_irq(k[0] ? 4'h2 : 4'h0);
      idle(16);
      if (k[1]) check("pin_edge_once", 8'h00, {7'h0, req});
      else check_irq(k[0] ? 4'h2 : 4'h0);
      pin_n[k[0]] = 1'b1;
      idle(16);
    end
    finish_test();
  end
endmodule : tb_ivsm_core

`default_nettype wire
